// >>> rtl/aux_pin_map.svh
`ifndef AUX_PIN_MAP_SVH
`define AUX_PIN_MAP_SVH
// register offsets
`define PIN_THREE_CONFIG_ADDR 8'h0F
`define PINS_FIVE_SIX_CONFIG_ADDR 8'h10
`define PINS_SEVEN_EIGHT_CONFIG_ADDR 8'h11
// field positions
`define LO_MODE_LSB 0
`define LO_VALUE_BIT 3
`define HI_MODE_LSB 4
`define HI_VALUE_BIT 7
// writable bits
`define PIN_THREE_WMASK 8'h0F
`define PAIR_WMASK 8'hBB
// reset value
`define CONFIG_RESET 8'h00
`endif

// >>> rtl/aux_pin_pkg.sv
package aux_pin_pkg;
   // decoded behaviour of one pin
   typedef enum logic [5:0]
   {
      PIN_FUNC_IN = 6'b00_0001,
      PIN_HIGH_Z = 6'b00_0010,
      PIN_REG_OUT = 6'b00_0100,
      PIN_REG_IN = 6'b00_1000,
      PIN_REMOTE_HOLD = 6'b01_0000,
      PIN_REMOTE_DEFAULT = 6'b10_0000
   } pin_mode_type;
endpackage : aux_pin_pkg

// >>> rtl/aux_pin_drive.sv
`timescale 1ns/1ps
// drive logic for one pin from its decoded mode
module aux_pin_drive
   import aux_pin_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // configuration
   input wire pin_mode_type i_mode,
   input wire logic i_value,
   // remote side
   input wire logic i_remote_value,
   input wire logic i_link_up,
   // pin
   input wire logic i_pin,
   output logic o_pin,
   output logic o_pin_oe,
   output logic o_func_en,
   output logic o_read_value
);
   logic hold_q;
   logic hold_d;

   // last value seen while the link is up
   always_comb
   begin
      hold_d = i_link_up ? i_remote_value : hold_q;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         hold_q <= 1'b0;
      else
         hold_q <= hold_d;
   end

   // registered pin drive
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_pin <= 1'b0;
         o_pin_oe <= 1'b0;
      end
      else
      begin
         unique case (i_mode)
            PIN_REG_OUT:
            begin
               o_pin <= i_value;
               o_pin_oe <= 1'b1;
            end
            PIN_REMOTE_HOLD:
            begin
               o_pin <= hold_d;
               o_pin_oe <= 1'b1;
            end
            PIN_REMOTE_DEFAULT:
            begin
               o_pin <= i_link_up ? i_remote_value : i_value;
               o_pin_oe <= 1'b1;
            end
            default:
            begin
               o_pin <= 1'b0;
               o_pin_oe <= 1'b0;
            end
         endcase
      end
   end

   // functional path enable and readable input
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_func_en <= 1'b0;
         o_read_value <= 1'b0;
      end
      else
      begin
         o_func_en <= (i_mode == PIN_FUNC_IN);
         o_read_value <= (i_mode == PIN_REG_IN) ? i_pin : 1'b0;
      end
   end

   a_reg_out_drive: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_mode == PIN_REG_OUT) |=> (o_pin_oe && o_pin == $past(i_value)))
      else $error("register output not driven");
   a_default_fallback: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_mode == PIN_REMOTE_DEFAULT && !i_link_up) |=> (o_pin == $past(i_value)))
      else $error("fallback value not driven");
   a_hold_on_loss: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_mode == PIN_REMOTE_HOLD && $past(i_mode) == PIN_REMOTE_HOLD && !i_link_up)
      |=> $stable(o_pin))
      else $error("held value changed on link loss");
endmodule : aux_pin_drive

// >>> rtl/gpio_pin_config_bank.sv
`timescale 1ns/1ps
// Summary of operation
// - pin three drives its value bit in register output mode and in mode 111 on link loss
// - pin three low bits 00 functional input, 10 high impedance
// - pin three 001 register output, 011 readable input
// - pin three 101 follows remote value, holds last on link loss
// - pin three 111 follows remote value, local bit on link loss
// - pins five and six two-bit modes decode four ways
// - pins seven and eight use the same four-way decode
// - pins five to eight drive value bits 3 and 7 in output mode
// - all configuration registers reset to zero
`include "aux_pin_map.svh"
module gpio_pin_config_bank
   import aux_pin_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 8
)
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // register port
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [ADDR_W-1:0] i_reg_addr,
   input wire logic [DATA_W-1:0] i_reg_wdata,
   output logic [DATA_W-1:0] o_reg_rdata,
   output logic o_reg_rvalid,
   // remote control for pin three
   input wire logic i_remote_value,
   input wire logic i_link_up,
   // pins: index 0 three, 1 five, 2 six, 3 seven, 4 eight
   input wire logic [4:0] i_pin,
   output logic [4:0] o_pin,
   output logic [4:0] o_pin_oe,
   output logic [4:0] o_func_en,
   output logic [4:0] o_read_value
);
   logic [DATA_W-1:0] three_q;
   logic [DATA_W-1:0] five_six_q;
   logic [DATA_W-1:0] seven_eight_q;
   pin_mode_type mode [5];
   logic [4:0] value;

   // three-bit decode for pin three
   function automatic pin_mode_type decode3(input logic [2:0] m);
      pin_mode_type r;
      r = PIN_FUNC_IN;
      if (m[1:0] == 2'b00)
         r = PIN_FUNC_IN;
      else if (m[1:0] == 2'b10)
         r = PIN_HIGH_Z;
      else if (m == 3'b001)
         r = PIN_REG_OUT;
      else if (m == 3'b011)
         r = PIN_REG_IN;
      else if (m == 3'b101)
         r = PIN_REMOTE_HOLD;
      else
         r = PIN_REMOTE_DEFAULT;
      return r;
   endfunction : decode3

   // two-bit decode for paired pins
   function automatic pin_mode_type decode2(input logic [1:0] m);
      pin_mode_type r;
      r = PIN_FUNC_IN;
      unique case (m)
         2'b00: r = PIN_FUNC_IN;
         2'b10: r = PIN_HIGH_Z;
         2'b01: r = PIN_REG_OUT;
         2'b11: r = PIN_REG_IN;
      endcase
      return r;
   endfunction : decode2

   // configuration register writes, reserved bits masked
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         three_q <= `CONFIG_RESET;
         five_six_q <= `CONFIG_RESET;
         seven_eight_q <= `CONFIG_RESET;
      end
      else if (i_reg_wr)
      begin
         if (i_reg_addr == `PIN_THREE_CONFIG_ADDR)
            three_q <= i_reg_wdata & `PIN_THREE_WMASK;
         if (i_reg_addr == `PINS_FIVE_SIX_CONFIG_ADDR)
            five_six_q <= i_reg_wdata & `PAIR_WMASK;
         if (i_reg_addr == `PINS_SEVEN_EIGHT_CONFIG_ADDR)
            seven_eight_q <= i_reg_wdata & `PAIR_WMASK;
      end
   end

   // register read, unmapped reads zero
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_reg_rdata <= '0;
         o_reg_rvalid <= 1'b0;
      end
      else
      begin
         o_reg_rvalid <= i_reg_rd;
         if (!i_reg_rd)
            o_reg_rdata <= '0;
         else if (i_reg_addr == `PIN_THREE_CONFIG_ADDR)
            o_reg_rdata <= three_q;
         else if (i_reg_addr == `PINS_FIVE_SIX_CONFIG_ADDR)
            o_reg_rdata <= five_six_q;
         else if (i_reg_addr == `PINS_SEVEN_EIGHT_CONFIG_ADDR)
            o_reg_rdata <= seven_eight_q;
         else
            o_reg_rdata <= '0;
      end
   end

   // mode and value decode per pin
   always_comb
   begin
      mode[0] = decode3(three_q[2:0]);
      mode[1] = decode2(five_six_q[`LO_MODE_LSB +: 2]);
      mode[2] = decode2(five_six_q[`HI_MODE_LSB +: 2]);
      mode[3] = decode2(seven_eight_q[`LO_MODE_LSB +: 2]);
      mode[4] = decode2(seven_eight_q[`HI_MODE_LSB +: 2]);
      value[0] = three_q[`LO_VALUE_BIT];
      value[1] = five_six_q[`LO_VALUE_BIT];
      value[2] = five_six_q[`HI_VALUE_BIT];
      value[3] = seven_eight_q[`LO_VALUE_BIT];
      value[4] = seven_eight_q[`HI_VALUE_BIT];
   end

   // one drive block per pin, remote path only on pin three
   generate
      for (genvar g = 0; g < 5; g++)
      begin : g_pin
         aux_pin_drive u_drive
         (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_mode(mode[g]),
            .i_value(value[g]),
            .i_remote_value((g == 0) ? i_remote_value : 1'b0),
            .i_link_up((g == 0) ? i_link_up : 1'b0),
            .i_pin(i_pin[g]),
            .o_pin(o_pin[g]),
            .o_pin_oe(o_pin_oe[g]),
            .o_func_en(o_func_en[g]),
            .o_read_value(o_read_value[g])
         );
      end
   endgenerate

   a_three_drive: assert property (@(posedge i_clk) disable iff (i_rst)
      (three_q[2:0] == 3'b001) |=> (o_pin_oe[0] && o_pin[0] == $past(three_q[3])))
      else $error("pin three register drive wrong");
   a_three_tristate: assert property (@(posedge i_clk) disable iff (i_rst)
      (three_q[1:0] == 2'b10) |=> (!o_pin_oe[0] && !o_func_en[0]))
      else $error("pin three not high impedance");
   a_three_funcin: assert property (@(posedge i_clk) disable iff (i_rst)
      (three_q[1:0] == 2'b00) |=> (o_func_en[0] && !o_pin_oe[0]))
      else $error("pin three not functional input");
   a_three_readin: assert property (@(posedge i_clk) disable iff (i_rst)
      (three_q[2:0] == 3'b011) |=> (!o_pin_oe[0] && o_read_value[0] == $past(i_pin[0])))
      else $error("pin three readable input wrong");
   a_three_remote: assert property (@(posedge i_clk) disable iff (i_rst)
      (three_q[2:0] == 3'b111 && i_link_up) |=> (o_pin[0] == $past(i_remote_value)))
      else $error("pin three remote value not driven");
   a_pair_out: assert property (@(posedge i_clk) disable iff (i_rst)
      (five_six_q[5:4] == 2'b01) |=> (o_pin_oe[2] && o_pin[2] == $past(five_six_q[7])))
      else $error("pin six output wrong");
   a_pair_hiz: assert property (@(posedge i_clk) disable iff (i_rst)
      (seven_eight_q[1:0] == 2'b10) |=> (!o_pin_oe[3] && !o_func_en[3]))
      else $error("pin seven not high impedance");
   a_reserved_zero: assert property (@(posedge i_clk) disable iff (i_rst)
      (three_q[7:4] == 4'h0 && five_six_q[6] == 1'b0 && seven_eight_q[2] == 1'b0))
      else $error("reserved bit set");
   a_reset_zero: assert property (@(posedge i_clk)
      i_rst |=> (three_q == 8'h00 && five_six_q == 8'h00 && seven_eight_q == 8'h00))
      else $error("config not zero after reset");
   a_reset_outputs: assert property (@(posedge i_clk)
      i_rst |=> (o_pin == 5'h00 && o_pin_oe == 5'h00 && o_func_en == 5'h00 && o_read_value == 5'h00))
      else $error("pin outputs not idle after reset");

   // pin three drive ownership and remote follow
   a_three_local_only: assert property (@(posedge i_clk) disable iff (i_rst)
      !(three_q[2:0] inside {3'b001, 3'b101, 3'b111}) |=> !o_pin_oe[0])
      else $error("pin three driven outside output modes");
   a_three_hold: assert property (@(posedge i_clk) disable iff (i_rst)
      (three_q[2:0] == 3'b101 && i_link_up) |=> (o_pin_oe[0] && o_pin[0] == $past(i_remote_value)))
      else $error("pin three hold mode not following remote");

   // paired pin decode and drive
   a_five_out: assert property (@(posedge i_clk) disable iff (i_rst)
      (five_six_q[1:0] == 2'b01) |=> (o_pin_oe[1] && o_pin[1] == $past(five_six_q[3])))
      else $error("pin five output wrong");
   a_five_funcin: assert property (@(posedge i_clk) disable iff (i_rst)
      (five_six_q[1:0] == 2'b00) |=> (o_func_en[1] && !o_pin_oe[1]))
      else $error("pin five not functional input");
   a_five_readin: assert property (@(posedge i_clk) disable iff (i_rst)
      (five_six_q[1:0] == 2'b11) |=> (!o_pin_oe[1] && o_read_value[1] == $past(i_pin[1])))
      else $error("pin five readable input wrong");
   a_six_hiz: assert property (@(posedge i_clk) disable iff (i_rst)
      (five_six_q[5:4] == 2'b10) |=> (!o_pin_oe[2] && !o_func_en[2]))
      else $error("pin six not high impedance");
   a_seven_out: assert property (@(posedge i_clk) disable iff (i_rst)
      (seven_eight_q[1:0] == 2'b01) |=> (o_pin_oe[3] && o_pin[3] == $past(seven_eight_q[3])))
      else $error("pin seven output wrong");
   a_seven_funcin: assert property (@(posedge i_clk) disable iff (i_rst)
      (seven_eight_q[1:0] == 2'b00) |=> (o_func_en[3] && !o_pin_oe[3]))
      else $error("pin seven not functional input");
   a_eight_out: assert property (@(posedge i_clk) disable iff (i_rst)
      (seven_eight_q[5:4] == 2'b01) |=> (o_pin_oe[4] && o_pin[4] == $past(seven_eight_q[7])))
      else $error("pin eight output wrong");
   a_eight_hiz: assert property (@(posedge i_clk) disable iff (i_rst)
      (seven_eight_q[5:4] == 2'b10) |=> (!o_pin_oe[4] && !o_func_en[4]))
      else $error("pin eight not high impedance");
   a_eight_readin: assert property (@(posedge i_clk) disable iff (i_rst)
      (seven_eight_q[5:4] == 2'b11) |=> (!o_pin_oe[4] && o_read_value[4] == $past(i_pin[4])))
      else $error("pin eight readable input wrong");
   a_six_readin: assert property (@(posedge i_clk) disable iff (i_rst)
      (five_six_q[5:4] == 2'b11) |=> (!o_pin_oe[2] && o_read_value[2] == $past(i_pin[2])))
      else $error("pin six readable input wrong");
endmodule : gpio_pin_config_bank

// >>> testbench/remote_deser_model.sv
`timescale 1ns/1ps
// behavioural remote end: lock state and pin three value
module remote_deser_model
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // stimulus from the bench
   input wire logic i_lock,
   input wire logic i_value,
   // link side
   output logic o_link_up,
   output logic o_remote_value
);
   // value toggles every cycle while lock is lost, so a stale level cannot pass
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_link_up <= 1'b0;
         o_remote_value <= 1'b0;
      end
      else
      begin
         o_link_up <= i_lock;
         o_remote_value <= i_lock ? i_value : ~o_remote_value;
      end
   end
endmodule : remote_deser_model

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; $display("FAIL t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
   import aux_pin_pkg::*;
   logic i_clk = 0, i_rst = 1, wr = 0, rd = 0, lock = 0, rval = 0, link_up, remote;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic [4:0] pin_in = 5'h0b, o_pin, o_pin_oe, o_func_en, o_read_value;
   logic rvalid;
   int fails = 0, n_compared = 0;

   // clock source
   initial
   begin
      forever #5 i_clk = ~i_clk;
   end

   gpio_pin_config_bank dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(wr), .i_reg_rd(rd),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
      .i_remote_value(remote), .i_link_up(link_up), .i_pin(pin_in), .o_pin(o_pin),
      .o_pin_oe(o_pin_oe), .o_func_en(o_func_en), .o_read_value(o_read_value));

   remote_deser_model peer_u (.i_clk(i_clk), .i_rst(i_rst), .i_lock(lock), .i_value(rval),
      .o_link_up(link_up), .o_remote_value(remote));

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      #1;
      wr = 1;
      addr = a;
      wdata = d;
      @(posedge i_clk);
      #1;
      wr = 0;
   endtask : wr_reg

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge i_clk);
      #1;
      rd = 1;
      addr = a;
      @(posedge i_clk);
      #1;
      rd = 0;
      `CHK(rvalid, 1'b1)
      `CHK(rdata, e)
   endtask : rd_chk

   // let config and pin outputs land
   task automatic settle;
      repeat (3) @(posedge i_clk);
      #1;
   endtask : settle

   // {oe, pin, func_en, read_value} for a two-bit mode
   function automatic logic [3:0] pin_exp(input logic [1:0] m, input logic v, input logic p);
      case (m)
         2'b00: return 4'b0010;
         2'b01: return {1'b1, v, 2'b00};
         2'b11: return {3'b000, p};
         default: return 4'b0000;
      endcase
   endfunction : pin_exp

   task automatic chk_pin(input int i, input logic [3:0] e);
      `CHK({o_pin_oe[i], o_pin[i], o_func_en[i], o_read_value[i]}, e)
   endtask : chk_pin

   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : complete_run

   // test sequence
   initial
   begin
      repeat (20) @(posedge i_clk);
      #1;
      i_rst = 0;
      settle;
      for (int a = 15; a < 18; a++) rd_chk(a[7:0], 8'h00);
      for (int i = 0; i < 5; i++) chk_pin(i, 4'b0010);
      $display("test reset done");
      wr_reg(8'h0f, 8'hff);
      rd_chk(8'h0f, 8'h0f);
      wr_reg(8'h10, 8'hff);
      rd_chk(8'h10, 8'hbb);
      wr_reg(8'h11, 8'hff);
      rd_chk(8'h11, 8'hbb);
      wr_reg(8'h12, 8'hff);
      rd_chk(8'h12, 8'h00);
      $display("test reserved done");
      lock = 1;
      rval = 0;
      for (int m = 0; m < 8; m++)
      begin
         wr_reg(8'h0f, {5'h01, m[2:0]});
         settle;
         chk_pin(0, (m[2] & m[0]) ? 4'b1000 : pin_exp(m[1:0], 1'b1, 1'b1));
      end
      $display("test pin three modes done");
      rval = 1;
      wr_reg(8'h0f, 8'h05);
      settle;
      chk_pin(0, 4'b1100);
      lock = 0;
      settle;
      chk_pin(0, 4'b1100);
      wr_reg(8'h0f, 8'h07);
      settle;
      chk_pin(0, 4'b1000);
      wr_reg(8'h0f, 8'h0f);
      settle;
      chk_pin(0, 4'b1100);
      $display("test link loss done");
      for (int m = 0; m < 4; m++)
      begin
         wr_reg(8'h10, {2'b10, m[1:0], 2'b10, m[1:0]});
         wr_reg(8'h11, {2'b00, m[1:0], 2'b10, m[1:0]});
         settle;
         chk_pin(1, pin_exp(m[1:0], 1'b1, pin_in[1]));
         chk_pin(2, pin_exp(m[1:0], 1'b1, pin_in[2]));
         chk_pin(3, pin_exp(m[1:0], 1'b1, pin_in[3]));
         chk_pin(4, pin_exp(m[1:0], 1'b0, pin_in[4]));
      end
      pin_in = 5'h14;
      settle;
      for (int i = 1; i < 5; i++) chk_pin(i, {3'b000, pin_in[i]});
      i_rst = 1;
      settle;
      i_rst = 0;
      settle;
      for (int a = 15; a < 18; a++) rd_chk(a[7:0], 8'h00);
      for (int i = 0; i < 5; i++) chk_pin(i, 4'b0010);
      $display("test paired pins done");
      complete_run;
   end
endmodule : tb_top
